// ### logic/adc_clock_divider.v
`include "adc_ctrl_defines.vh"

// Prescaler that turns the system clock into a one-cycle converter tick
module adc_clock_divider (
   // Clock and reset
   input  wire       clk,
   input  wire       rst_n,
   // Control
   input  wire       run,
   input  wire       restart,
   input  wire [2:0] divide_sel,
   // Tick out
   output reg        tick
);

   reg  [6:0] count;        // Free counter inside the prescaler
   reg  [6:0] limit;        // Terminal value for the chosen divisor

   ////////////////////////////////////////////////////////////////////////
   // Codes 0 and 1 both divide by two, then each code doubles
   always @* begin
      case (divide_sel)
         3'h0, 3'h1: limit = 7'h01;
         3'h2:       limit = 7'h03;
         3'h3:       limit = 7'h07;
         3'h4:       limit = 7'h0F;
         3'h5:       limit = 7'h1F;
         3'h6:       limit = 7'h3F;
         default:    limit = 7'h7F;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter held in reset while off to save toggling
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 7'h00;
         tick  <= 1'b0;
      end else if (!run || restart) begin
         count <= 7'h00;
         tick  <= 1'b0;
      end else if (count >= limit) begin
         count <= 7'h00;
         tick  <= 1'b1;
      end else begin
         count <= count + 7'h01;
         tick  <= 1'b0;
      end
   end

endmodule

// ### logic/adc_conv_ctrl.v
`include "adc_ctrl_defines.vh"

// Functional notes
// - Ten-bit result, code equals vin times 1024 over vref
// - Channel code 1000 routes and enables temperature sensor
// - Bits 7 and 4 read zero, ignore writes
// - Reference bit selects bandgap or analog supply
// - Reference change waits for conversion end
// - Justification applies immediately to held result
// - Channel codes map to inputs, bandgap, ground
// - Channel change waits for conversion end
// - Enable bit powers converter; clearing aborts conversion
// - Go starts conversion; free running repeats automatically
// - First conversion after enable lasts 25 cycles
// - Go reads one while conversion runs
// - Writing zero to go is ignored
// - Completed result held in result registers
// - Done flag set at completion, cleared by one
// - Divide select gives two up to 128
// - Auto trigger starts conversion on rising edge
// - Low byte read locks result until high read
module adc_conv_ctrl (
   // Clock and reset
   input  wire       clk,
   input  wire       rst_n,
   // Register port
   input  wire [3:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr_en,
   input  wire       rd_en,
   output reg  [7:0] rdata,
   // Analog front end
   output reg  [3:0] mux_sel,
   output reg        ref_sel,
   output reg        temp_sensor_en,
   output reg        converter_power,
   output reg        sample_hold,
   output reg        sar_start,
   input  wire [9:0] sar_code,
   // Trigger and interrupt request
   input  wire       trigger_in,
   input  wire       irq_ack,
   output wire       conv_done_irq
);

   ////////////////////////////////////////////////////////////////////////
   // Sequencer states
   localparam IDLE = 2'b00;
   localparam CONV = 2'b01;
   // Two states are enough: the first conversion differs only in length,
   // and free running re-enters CONV directly at completion.
   // The unused codes fall back to IDLE.

   // Software-visible register fields

   reg  [7:0] chan_ref;        // Software copy of channel_ref_select_reg
   reg        converter_on;    // Converter enable
   reg        conv_go;         // Busy / start bit
   reg        auto_trigger_on; // Auto trigger enable
   reg        conv_done_flag;  // Sticky completion flag
   reg        conv_done_irq_en;// Completion interrupt enable
   reg  [2:0] clock_divide_sel;// Prescaler code

   // Sequencer state
   reg  [1:0] state;           // Sequencer state
   reg  [4:0] cyc;             // Converter cycles elapsed
   reg  [4:0] cyc_len;         // Length of the running conversion
   reg        first_pending;   // Next conversion is the long first one
   reg        start_req;       // Start waiting for the next tick
   reg  [9:0] result;          // Held result
   reg        result_lock;     // Low byte read, high not yet

   // Trigger input path
   reg        trig_s1;         // Trigger synchroniser, first stage
   reg        trig_s2;         // Trigger synchroniser, second stage
   reg        trig_d;          // Previous trigger level
   reg  [7:0] next_rdata;      // Read mux
   reg  [7:0] res_lo;          // Justified low byte
   reg  [7:0] res_hi;          // Justified high byte

   // Derived strobes
   wire       tick;            // Converter clock enable
   wire       trig_rise;       // Rising trigger edge
   wire       wr_ctrl;         // Write to control/status register
   wire       done_now;        // Conversion completes this cycle

   // Decoded strobes and events. done_now marks the tick that ends the
   // last converter cycle; the flag sets on it, the result loads on it
   // unless locked, and the busy bit clears on it unless free running.
   assign wr_ctrl   = wr_en && (addr == `ADDR_CTRL_STAT);
   assign trig_rise = trig_s2 && !trig_d;
   assign done_now  = (state == CONV) && tick && (cyc == cyc_len - 5'h01);
   assign conv_done_irq = conv_done_flag && conv_done_irq_en;

   ////////////////////////////////////////////////////////////////////////
   // Prescaler; restarts on trigger for a fixed trigger-to-start delay
   // Powering down stops the count, so the first tick after enable comes
   // one full period later whatever the count was before.
   adc_clock_divider u_div (
      .clk        (clk),
      .rst_n      (rst_n),
      .run        (converter_on),
      .restart    (auto_trigger_on && trig_rise && state == IDLE),
      .divide_sel (clock_divide_sel),
      .tick       (tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Trigger pin passes two flops before edge detection
   // trig_d resets low, matching the idle pin level, so no false edge
   // appears when reset is released.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_d  <= 1'b0;
      end else begin
         trig_s1 <= trigger_in;
         trig_s2 <= trig_s1;
         trig_d  <= trig_s2;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel/reference register; reserved bits never stored
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         chan_ref <= `RST_CHAN_REF;
      else if (wr_en && addr == `ADDR_CHAN_REF)
         chan_ref <= wdata & `CHAN_REF_WMASK;
   end

   ////////////////////////////////////////////////////////////////////////
   // Selection follows software except while converting. It reopens in
   // the last converter cycle so the next conversion sees new values.
   // Writes made during a conversion sit in chan_ref until then, so the
   // register reads back the new value before the mux follows it.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mux_sel        <= 4'h0;
         ref_sel        <= 1'b0;
         temp_sensor_en <= 1'b0;
      end else if (state != CONV || cyc == cyc_len - 5'h01) begin
         mux_sel        <= chan_ref[`CHAN_MSB:0];
         ref_sel        <= chan_ref[`BIT_REF_SEL];
         // Reserved codes pass through and pick no input
         temp_sensor_en <= (chan_ref[`CHAN_MSB:0] == `CHAN_TEMP);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control/status register and conversion sequencer
   // A go written while busy is dropped rather than queued; software
   // polls the busy bit before starting again.
   // Power down is checked first so an abort wins over any start
   // requested in the same cycle.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         converter_on     <= 1'b0;
         conv_go          <= 1'b0;
         auto_trigger_on  <= 1'b0;
         conv_done_flag   <= 1'b0;
         conv_done_irq_en <= 1'b0;
         clock_divide_sel <= 3'h0;
         state            <= IDLE;
         cyc              <= 5'h00;
         cyc_len          <= `CYC_NORMAL;
         first_pending    <= 1'b0;
         start_req        <= 1'b0;
         converter_power  <= 1'b0;
         sample_hold      <= 1'b0;
         sar_start        <= 1'b0;
      end else begin
         sar_start <= 1'b0;
         if (wr_ctrl) begin
            converter_on     <= wdata[`BIT_CONV_ON];
            auto_trigger_on  <= wdata[`BIT_AUTO_TRIG];
            conv_done_irq_en <= wdata[`BIT_IRQ_EN];
            clock_divide_sel <= wdata[`DIV_MSB:0];
            // Enabling arms the long first conversion
            if (wdata[`BIT_CONV_ON] && !converter_on)
               first_pending <= 1'b1;
         end
         // Completion beats a same-cycle clear of the flag
         if (done_now)
            conv_done_flag <= 1'b1;
         else if (irq_ack || (wr_ctrl && wdata[`BIT_DONE_FLAG]))
            conv_done_flag <= 1'b0;
         converter_power <= wr_ctrl ? wdata[`BIT_CONV_ON] : converter_on;
         if (wr_ctrl && !wdata[`BIT_CONV_ON]) begin
            // Power down aborts whatever is running
            state       <= IDLE;
            conv_go     <= 1'b0;
            start_req   <= 1'b0;
            sample_hold <= 1'b0;
            cyc         <= 5'h00;
         end else begin
            // Only a one written to go starts; zero is ignored
            if (wr_ctrl && wdata[`BIT_CONV_GO] && state == IDLE) begin
               start_req <= 1'b1;
               conv_go   <= 1'b1;
            end
            if (auto_trigger_on && converter_on && trig_rise &&
                state == IDLE) begin
               start_req <= 1'b1;
               conv_go   <= 1'b1;
            end
            case (state)
               IDLE: begin
                  if (start_req && tick) begin
                     state         <= CONV;
                     cyc           <= 5'h00;
                     start_req     <= 1'b0;
                     sar_start     <= 1'b1;
                     sample_hold   <= 1'b1;
                     cyc_len       <= first_pending ? `CYC_FIRST
                                                    : `CYC_NORMAL;
                     first_pending <= 1'b0;
                  end
               end
               CONV: begin
                  if (tick) begin
                     cyc <= cyc + 5'h01;
                     if (cyc == 5'h01)
                        sample_hold <= 1'b0;
                     if (done_now) begin
                        cyc <= 5'h00;
                        if (auto_trigger_on) begin
                           // Free running restarts on the spot
                           state       <= CONV;
                           cyc_len     <= `CYC_NORMAL;
                           sar_start   <= 1'b1;
                           sample_hold <= 1'b1;
                        end else begin
                           state   <= IDLE;
                           conv_go <= 1'b0;
                        end
                     end
                  end
               end
               default: state <= IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result capture; held while the low byte has been read alone
   // A completion that meets the lock is lost, not deferred: keeping it
   // would need a second result register for little gain.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result      <= `RST_RESULT;
         result_lock <= 1'b0;
      end else begin
         if (rd_en && addr == `ADDR_RES_LOW)
            result_lock <= 1'b1;
         else if (rd_en && addr == `ADDR_RES_HIGH)
            result_lock <= 1'b0;
         // Code is vin*1024/vref, 0x000 to 0x3FF
         if (done_now && !result_lock)
            result <= sar_code;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Justification is combinational so a toggle shows at once
   // Only the presentation changes; the held code itself is untouched.
   always @* begin
      if (chan_ref[`BIT_LEFT_JUST]) begin
         res_hi = result[9:2];
         res_lo = {result[1:0], 6'h00};
      end else begin
         res_hi = {6'h00, result[9:8]};
         res_lo = result[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unmapped addresses read zero
   always @* begin
      case (addr)
         `ADDR_CHAN_REF:  next_rdata = chan_ref;
         `ADDR_CTRL_STAT: next_rdata = {converter_on, conv_go,
                                        auto_trigger_on, conv_done_flag,
                                        conv_done_irq_en, clock_divide_sel};
         `ADDR_RES_LOW:   next_rdata = res_lo;
         `ADDR_RES_HIGH:  next_rdata = res_hi;
         default:         next_rdata = 8'h00;
      endcase
   end

   // Returning zero between reads keeps the bus quiet and lets a
   // checker spot data outside its slot.
   // Read data stands only in the cycle after the strobe
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         rdata <= 8'h00;
      else if (rd_en)
         rdata <= next_rdata;
      else
         rdata <= 8'h00;
   end

endmodule

// ### logic/adc_ctrl_defines.vh
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// Register addresses (4-bit register index space)
`define ADDR_CHAN_REF      4'h0
`define ADDR_CTRL_STAT     4'h1
`define ADDR_RES_LOW       4'h2
`define ADDR_RES_HIGH      4'h3
`define ADDR_TRIG_SEL      4'h4

// Field positions in channel_ref_select_reg
`define BIT_REF_SEL        6
`define BIT_LEFT_JUST      5
`define CHAN_MSB           3

// Field positions in conv_control_status_reg
`define BIT_CONV_ON        7
`define BIT_CONV_GO        6
`define BIT_AUTO_TRIG      5
`define BIT_DONE_FLAG      4
`define BIT_IRQ_EN         3
`define DIV_MSB            2

// Reset values
`define RST_CHAN_REF       8'h00
`define RST_CTRL_STAT      8'h00
`define RST_RESULT         10'h000

// Channel codes
`define CHAN_TEMP          4'h8

// Conversion lengths in converter clock cycles
`define CYC_FIRST          5'h19
`define CYC_NORMAL         5'h0D

// Mask of writable bits in channel_ref_select_reg
`define CHAN_REF_WMASK     8'h6F

`endif

// ### test/adc_conv_ctrl_props.sv
`include "adc_ctrl_defines.vh"
// Port-level checker for the converter control block
module adc_conv_ctrl_props (
   // Clock and reset
   input wire       clk,
   input wire       rst_n,
   // Register port
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire       wr_en,
   input wire       rd_en,
   input wire [7:0] rdata,
   // Analog front end
   input wire [3:0] mux_sel,
   input wire       ref_sel,
   input wire       temp_sensor_en,
   input wire       converter_power,
   input wire       sample_hold,
   input wire       sar_start,
   // Interrupt request
   input wire       conv_done_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   // Clocks since the last start; parked high while powered down, so an
   // abort followed by a quick restart is not taken for a short cycle
   logic [7:0] gap;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         gap <= 8'hFF;
      else if (sar_start)
         gap <= 8'h01;
      else if (!converter_power || gap == 8'hFF)
         gap <= 8'hFF;
      else
         gap <= gap + 8'h01;
   end
   ////////////////////////////////////////////////////////////////////////
   temp_sense_a: assert property (temp_sensor_en == (mux_sel == 4'h8))
      else $error("temp sensor enable disagrees with channel");
   rsvd_zero_a: assert property ($past(rd_en) &&
      $past(addr) == `ADDR_CHAN_REF |-> !rdata[7] && !rdata[4])
      else $error("reserved select bits read nonzero");
   rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 8'h00)
      else $error("read data outside its slot");
   power_write_a: assert property (wr_en && addr == `ADDR_CTRL_STAT
      |=> converter_power == $past(wdata[7]))
      else $error("converter power does not follow enable write");
   start_power_a: assert property (sar_start |-> converter_power)
      else $error("start while powered down");
   hold_start_a: assert property (sar_start |-> sample_hold ##1 sample_hold)
      else $error("sample and hold not raised at start");
   start_pulse_a: assert property (sar_start |=> !sar_start)
      else $error("start pulse longer than one cycle");
   sel_lock_a: assert property (sar_start |-> ##2
      (($stable(mux_sel) && $stable(ref_sel)) || !converter_power) [*8])
      else $error("selection moved during conversion");
   start_gap_a: assert property (sar_start |-> gap >= 8'h1A)
      else $error("conversions closer than thirteen ticks");
   irq_mask_a: assert property (wr_en && addr == `ADDR_CTRL_STAT &&
      !wdata[3] |=> !conv_done_irq)
      else $error("interrupt raised while disabled");
endmodule

bind adc_conv_ctrl adc_conv_ctrl_props adc_conv_ctrl_props_inst (
   .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
   .rd_en(rd_en), .rdata(rdata), .mux_sel(mux_sel), .ref_sel(ref_sel),
   .temp_sensor_en(temp_sensor_en), .converter_power(converter_power),
   .sample_hold(sample_hold),
   .sar_start(sar_start), .conv_done_irq(conv_done_irq));

// ### test/adc_conv_ctrl_tb_top.sv
`include "adc_ctrl_defines.vh"
module adc_conv_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   // Stimulus, all given a value at time zero
   logic       clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
   logic       trigger_in = 1'b0, irq_ack = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [9:0] sar_code = 10'h000;
   // Observed outputs
   wire  [7:0] rdata;
   wire  [3:0] mux_sel;
   wire        ref_sel, temp_sensor_en, converter_power, sample_hold;
   wire        sar_start, conv_done_irq;
   int         error_cnt = 0, n_compared = 0, cyc = 0, starts = 0, t0;

   adc_conv_ctrl adc_conv_ctrl_inst (.clk(clk), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .mux_sel(mux_sel), .ref_sel(ref_sel), .temp_sensor_en(temp_sensor_en),
      .converter_power(converter_power), .sample_hold(sample_hold),
      .sar_start(sar_start), .sar_code(sar_code), .trigger_in(trigger_in),
      .irq_ack(irq_ack), .conv_done_irq(conv_done_irq));

   ////////////////////////////////////////////////////////////////////////
   always #4 clk = ~clk;
   // Cycle count for timing windows, and a tally of conversion starts
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (sar_start === 1'b1)
         starts <= starts + 1;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [9:0] e, g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One-cycle strobes; a clock edge always separates two strobes
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // Read data is looked at only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic rchk(input string nm, input logic [3:0] a,
                       input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk(nm, {2'b00, e}, {2'b00, v});
   endtask
   // Poll the busy bit; elapsed time since t0 must fall in [lo, hi]
   task automatic wait_done(input int lo, hi);
      logic [7:0] v;
      int n;
      v = 8'h40;
      for (n = 0; n < 2000 && v[6] !== 1'b0; n++)
         rd(`ADDR_CTRL_STAT, v);
      if (v[6] !== 1'b0) begin
         error_cnt++;
         $display("[FAIL] busy_wait expected 0 seen %b", v[6]);
         give_verdict();
      end else
         chk("conv_time", 10'h001, {9'h000, cyc - t0 >= lo && cyc - t0 <= hi});
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      int c, d, s0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values, including the unused index
      for (c = 0; c < 5; c++)
         rchk("reset_value", c[3:0], 8'h00);
      // Every channel code, reserved bits written as ones
      for (c = 0; c < 16; c++) begin
         wr(`ADDR_CHAN_REF, {1'b1, c[0], c[1], 1'b1, c[3:0]});
         rchk("chan_reg", `ADDR_CHAN_REF, {1'b0, c[0], c[1], 1'b0, c[3:0]});
         chk("mux", {6'h00, c[3:0]}, {6'h00, mux_sel});
         chk("temp_en", {9'h000, c == 8}, {9'h000, temp_sensor_en});
         chk("ref", {9'h000, c[0]}, {9'h000, ref_sel});
      end
      // First conversion, enable and start together; selection and a
      // zero go write arrive while it runs
      wr(`ADDR_CHAN_REF, 8'h00);
      sar_code <= 10'h2B5;
      t0 = cyc;
      wr(`ADDR_CTRL_STAT, 8'hC0);
      repeat (4) @(posedge clk);
      wr(`ADDR_CHAN_REF, 8'h4F);
      wr(`ADDR_CTRL_STAT, 8'h80);
      rchk("go_busy", `ADDR_CTRL_STAT, 8'hC0);
      chk("mux_locked", 10'h000, {6'h00, mux_sel});
      chk("ref_locked", 10'h000, {9'h000, ref_sel});
      wait_done(50, 62);
      chk("mux_applied", 10'h00F, {6'h00, mux_sel});
      chk("ref_applied", 10'h001, {9'h000, ref_sel});
      rchk("done_set", `ADDR_CTRL_STAT, 8'h90);
      rchk("res_low", `ADDR_RES_LOW, 8'hB5);
      rchk("res_high", `ADDR_RES_HIGH, 8'h02);
      wr(`ADDR_CHAN_REF, 8'h2F);
      rchk("left_high", `ADDR_RES_HIGH, 8'hAD);
      rchk("left_low", `ADDR_RES_LOW, 8'h40);
      wr(`ADDR_CTRL_STAT, 8'h90);
      rchk("done_clear", `ADDR_CTRL_STAT, 8'h80);
      // Low byte read last, so this result must be dropped
      sar_code <= 10'h155;
      t0 = cyc;
      wr(`ADDR_CTRL_STAT, 8'hC0);
      wait_done(26, 38);
      rchk("locked_high", `ADDR_RES_HIGH, 8'hAD);
      // Every divider code, with interrupt raised and acknowledged
      wr(`ADDR_CHAN_REF, 8'h0F);
      for (c = 0; c < 8; c++) begin
         d = (c == 0) ? 2 : (1 << c);
         t0 = cyc;
         wr(`ADDR_CTRL_STAT, {5'b11011, c[2:0]});
         wait_done(13 * d, 15 * d + 8);
         chk("irq_up", 10'h001, {9'h000, conv_done_irq});
         @(posedge clk) irq_ack <= 1'b1;
         @(posedge clk) irq_ack <= 1'b0;
         #1 chk("irq_ack", 10'h000, {9'h000, conv_done_irq});
      end
      rchk("new_low", `ADDR_RES_LOW, 8'h55);
      rchk("new_high", `ADDR_RES_HIGH, 8'h01);
      // Abort mid-conversion, then re-enable: long first conversion again
      wr(`ADDR_CTRL_STAT, 8'hC0);
      repeat (6) @(posedge clk);
      wr(`ADDR_CTRL_STAT, 8'h00);
      rchk("abort", `ADDR_CTRL_STAT, 8'h00);
      chk("power_off", 10'h000, {9'h000, converter_power});
      t0 = cyc;
      wr(`ADDR_CTRL_STAT, 8'hC0);
      wait_done(50, 62);
      // Temperature reading: sensor channel, internal reference, single
      wr(`ADDR_CHAN_REF, 8'h08);
      t0 = cyc;
      wr(`ADDR_CTRL_STAT, 8'hC0);
      wait_done(26, 38);
      chk("temp_on", 10'h001, {9'h000, temp_sensor_en});
      chk("temp_ref", 10'h000, {9'h000, ref_sel});
      // Trigger edge starts a conversion, then it keeps running alone
      wr(`ADDR_CTRL_STAT, 8'hB0);
      s0 = starts;
      @(posedge clk) trigger_in <= 1'b1;
      repeat (4) @(posedge clk);
      trigger_in <= 1'b0;
      repeat (300) @(posedge clk);
      chk("free_run", 10'h001, {9'h000, starts - s0 >= 6});
      wr(`ADDR_CTRL_STAT, 8'h00);
      give_verdict();
   end
endmodule
